// ==== vic_pkg.sv ====
package vic_pkg;

	// ****************************************
	// Sources, in priority order
	// ****************************************
	localparam int unsigned NUM_SRC = 8;
	localparam int unsigned NUM_PINS = 3;
	localparam logic [2:0] SRC_WATCHDOG = 3'h0;
	localparam logic [2:0] SRC_PIN_ZERO = 3'h1;
	localparam logic [2:0] SRC_PIN_ONE = 3'h2;
	localparam logic [2:0] SRC_PIN_TWO = 3'h3;
	localparam logic [2:0] SRC_SERIAL_RX = 3'h4;
	localparam logic [2:0] SRC_SERIAL_TX = 3'h5;
	localparam logic [2:0] SRC_BYTE_TIMER = 3'h6;
	localparam logic [2:0] SRC_WORD_TIMER = 3'h7;

	// ****************************************
	// Vector table
	// ****************************************
	localparam logic [15:0] VEC_NMI = 16'h0004;
	localparam logic [15:0] VEC_WATCHDOG = 16'h0004;
	localparam logic [15:0] VEC_PIN_ZERO = 16'h0006;
	localparam logic [15:0] VEC_PIN_ONE = 16'h0008;
	localparam logic [15:0] VEC_PIN_TWO = 16'h000a;
	localparam logic [15:0] VEC_SERIAL_RX = 16'h000c;
	localparam logic [15:0] VEC_SERIAL_TX = 16'h000e;
	localparam logic [15:0] VEC_BYTE_TIMER = 16'h0014;
	localparam logic [15:0] VEC_WORD_TIMER = 16'h0016;

	// ****************************************
	// Register map, byte addresses
	// ****************************************
	localparam logic [5:0] OFF_REQ_LOW = 6'h00;
	localparam logic [5:0] OFF_REQ_HIGH = 6'h04;
	localparam logic [5:0] OFF_MASK_LOW = 6'h08;
	localparam logic [5:0] OFF_MASK_HIGH = 6'h0c;
	localparam logic [5:0] OFF_EDGE_SEL = 6'h10;
	localparam logic [5:0] OFF_PSW = 6'h14;
	localparam logic [5:0] OFF_WDT_MODE = 6'h18;
	localparam logic [5:0] OFF_EVT_STATUS = 6'h1c;
	localparam logic [5:0] OFF_EVT_MASK = 6'h20;

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam int unsigned LOW_FLAGS = 6;
	localparam int unsigned HIGH_FLAGS = 2;
	localparam int unsigned EDGE_SEL_LSB = 2;
	localparam int unsigned IE_BIT = 7;
	localparam logic [7:0] PSW_RESET = 8'h02;
	localparam logic [7:0] MASK_RESET = 8'hff;
	localparam logic [7:0] EDGE_SEL_RESET = 8'h00;
	localparam int unsigned EVT_NMI_TAKEN = 0;
	localparam int unsigned EVT_MASKABLE_TAKEN = 1;
	localparam int unsigned EVT_BAD_EDGE = 2;
	localparam int unsigned NUM_EVT = 3;

	typedef enum logic [1:0] {
		EDGE_FALL = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_PROHIBITED = 2'h2,
		EDGE_BOTH = 2'h3
	} edge_mode_t;

endpackage

// ==== edge_if.sv ====
`timescale 1ns/1ns
interface edge_if;
	logic pin;
	logic [1:0] mode;
	logic hit;
	modport detector (input pin, input mode, output hit);
	modport owner (output pin, output mode, input hit);
endinterface

// ==== pin_edge_detect.sv ====
`timescale 1ns/1ns
module pin_edge_detect (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pin and detected edge
	edge_if.detector link
);
	import vic_pkg::*;

	// ****************************************
	// Three-stage synchroniser
	// ****************************************
	logic sync_a;
	logic sync_b;
	logic sync_c;
	logic level;
	logic primed;
	logic settled;
	logic rising;
	logic falling;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			sync_c <= 1'b0;
		end else begin
			sync_a <= link.pin;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	// A change counts only once the last two stages agree
	assign settled = (sync_b == sync_c);
	assign rising = settled && primed && sync_b && !level;
	assign falling = settled && primed && !sync_b && level;

	// First settled level after reset is the synchroniser's reset low, taken silently, so an idle-high pin still gives one rising edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level <= 1'b0;
			primed <= 1'b0;
		end else if (settled) begin
			level <= sync_b;
			primed <= 1'b1;
		end
	end

	// ****************************************
	// Edge selection
	// ****************************************
	always_comb begin
		unique case (edge_mode_t'(link.mode))
			EDGE_FALL: link.hit = falling;
			EDGE_RISE: link.hit = rising;
			EDGE_BOTH: link.hit = rising || falling;
			default: link.hit = 1'b0;
		endcase
	end

endmodule

// ==== vectored_interrupt_controller.sv ====
`timescale 1ns/1ns
module vectored_interrupt_controller (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Interrupt sources
	input wire logic watchdog_irq_i,
	input wire logic pin_irq_zero_i,
	input wire logic pin_irq_one_i,
	input wire logic pin_irq_two_i,
	input wire logic async_rx_done_irq_i,
	input wire logic three_wire_done_irq_i,
	input wire logic async_tx_done_irq_i,
	input wire logic byte_timer_match_irq_i,
	input wire logic word_timer_match_irq_i,
	// Processor side
	input wire logic irq_ack_i,
	output logic irq_req_o,
	output logic irq_nmi_o,
	output logic [15:0] irq_vector_o,
	output logic standby_release_o,
	// Event interrupt
	output logic irq_o
);
	import vic_pkg::*;

	// ****************************************
	// State
	// ****************************************
	logic [NUM_SRC-1:0] req_flags;
	logic [NUM_SRC-1:0] mask_flags;
	logic [7:0] edge_sel;
	logic [7:0] processor_status_word;
	logic wdt_nmi_mode;
	logic nmi_pending;
	logic [2:0] served_idx;
	logic [NUM_EVT-1:0] evt_status;
	logic [NUM_EVT-1:0] evt_mask;

	logic [NUM_SRC-1:0] hw_set;
	logic [NUM_SRC-1:0] ack_clr;
	logic [NUM_SRC-1:0] next_req_flags;
	logic [NUM_SRC-1:0] eligible;
	logic next_ie;
	logic next_nmi_pending;
	logic next_any;
	logic [2:0] next_idx;
	logic [NUM_PINS-1:0] pin_hit;
	logic [NUM_PINS-1:0] pin_level;

	// ****************************************
	// Bus decode
	// ****************************************
	logic access;
	logic wr_byte;
	logic rd_strobe;
	logic nmi_ack;
	logic mask_ack;

	assign access = cyc_i && stb_i && !ack_o;
	assign wr_byte = access && we_i && sel_i[0];
	assign rd_strobe = access && !we_i;
	assign nmi_ack = irq_ack_i && irq_req_o && irq_nmi_o;
	assign mask_ack = irq_ack_i && irq_req_o && !irq_nmi_o;

	function automatic logic hits(input logic [5:0] adr, input logic [5:0] off);
		hits = (adr[5:2] == off[5:2]);
	endfunction

	function automatic logic [15:0] vector_of(input logic [2:0] idx);
		unique case (idx)
			SRC_WATCHDOG: vector_of = VEC_WATCHDOG;
			SRC_PIN_ZERO: vector_of = VEC_PIN_ZERO;
			SRC_PIN_ONE: vector_of = VEC_PIN_ONE;
			SRC_PIN_TWO: vector_of = VEC_PIN_TWO;
			SRC_SERIAL_RX: vector_of = VEC_SERIAL_RX;
			SRC_SERIAL_TX: vector_of = VEC_SERIAL_TX;
			SRC_BYTE_TIMER: vector_of = VEC_BYTE_TIMER;
			SRC_WORD_TIMER: vector_of = VEC_WORD_TIMER;
		endcase
	endfunction

	// ****************************************
	// External pins
	// ****************************************
	assign pin_level = {pin_irq_two_i, pin_irq_one_i, pin_irq_zero_i};

	generate
		for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
			edge_if link();
			assign link.pin = pin_level[p];
			assign link.mode = edge_sel[EDGE_SEL_LSB + 2 * p +: 2];
			assign pin_hit[p] = link.hit;
			pin_edge_detect u_det (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.link(link)
			);
		end
	endgenerate

	// ****************************************
	// Request sources
	// ****************************************
	always_comb begin
		hw_set = '0;
		hw_set[SRC_WATCHDOG] = watchdog_irq_i && !wdt_nmi_mode;
		hw_set[SRC_PIN_ZERO] = pin_hit[0];
		hw_set[SRC_PIN_ONE] = pin_hit[1];
		hw_set[SRC_PIN_TWO] = pin_hit[2];
		hw_set[SRC_SERIAL_RX] = async_rx_done_irq_i || three_wire_done_irq_i;
		hw_set[SRC_SERIAL_TX] = async_tx_done_irq_i;
		hw_set[SRC_BYTE_TIMER] = byte_timer_match_irq_i;
		hw_set[SRC_WORD_TIMER] = word_timer_match_irq_i;
	end

	always_comb begin
		ack_clr = '0;
		if (mask_ack) begin
			ack_clr[served_idx] = 1'b1;
		end
	end

	// Software write first, then acknowledge clear, then a fresh request wins over both
	always_comb begin
		next_req_flags = req_flags;
		if (wr_byte && hits(adr_i, OFF_REQ_LOW)) begin
			next_req_flags[LOW_FLAGS-1:0] = dat_i[LOW_FLAGS-1:0];
		end
		if (wr_byte && hits(adr_i, OFF_REQ_HIGH)) begin
			next_req_flags[NUM_SRC-1:LOW_FLAGS] = dat_i[HIGH_FLAGS-1:0];
		end
		next_req_flags = (next_req_flags & ~ack_clr) | hw_set;
	end

	// Acknowledge clears the global enable as the processor stacks its status
	always_comb begin
		next_ie = processor_status_word[IE_BIT];
		if (wr_byte && hits(adr_i, OFF_PSW)) begin
			next_ie = dat_i[IE_BIT];
		end
		if (nmi_ack || mask_ack) begin
			next_ie = 1'b0;
		end
	end

	assign next_nmi_pending = (watchdog_irq_i && wdt_nmi_mode) || (nmi_pending && !nmi_ack);

	// ****************************************
	// Arbitration
	// ****************************************
	assign eligible = next_req_flags & ~mask_flags;

	always_comb begin
		next_idx = SRC_WORD_TIMER;
		next_any = 1'b0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (eligible[i]) begin
				next_idx = 3'(i);
				next_any = 1'b1;
			end
		end
	end

	// Offer follows the flag state of the same edge, so an acked source never repeats
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_req_o <= 1'b0;
			irq_nmi_o <= 1'b0;
			irq_vector_o <= '0;
			served_idx <= SRC_WATCHDOG;
		end else if (next_nmi_pending) begin
			irq_req_o <= 1'b1;
			irq_nmi_o <= 1'b1;
			irq_vector_o <= VEC_NMI;
			served_idx <= next_idx;
		end else begin
			irq_req_o <= next_any && next_ie;
			irq_nmi_o <= 1'b0;
			irq_vector_o <= vector_of(next_idx);
			served_idx <= next_idx;
		end
	end

	// Wakes a halted core even with the global enable off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			standby_release_o <= 1'b0;
		end else begin
			standby_release_o <= next_nmi_pending || next_any;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_flags <= '0;
		end else begin
			req_flags <= next_req_flags;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nmi_pending <= 1'b0;
		end else begin
			nmi_pending <= next_nmi_pending;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_flags <= MASK_RESET;
		end else begin
			if (wr_byte && hits(adr_i, OFF_MASK_LOW)) begin
				mask_flags[LOW_FLAGS-1:0] <= dat_i[LOW_FLAGS-1:0];
			end
			if (wr_byte && hits(adr_i, OFF_MASK_HIGH)) begin
				mask_flags[NUM_SRC-1:LOW_FLAGS] <= dat_i[HIGH_FLAGS-1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			edge_sel <= EDGE_SEL_RESET;
		end else if (wr_byte && hits(adr_i, OFF_EDGE_SEL)) begin
			edge_sel <= {dat_i[7:EDGE_SEL_LSB], EDGE_SEL_RESET[EDGE_SEL_LSB-1:0]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			processor_status_word <= PSW_RESET;
		end else begin
			if (wr_byte && hits(adr_i, OFF_PSW)) begin
				processor_status_word <= dat_i[7:0];
			end
			processor_status_word[IE_BIT] <= next_ie;
		end
	end

	// Interval mode after reset; software picks one watchdog form only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wdt_nmi_mode <= 1'b0;
		end else if (wr_byte && hits(adr_i, OFF_WDT_MODE)) begin
			wdt_nmi_mode <= dat_i[0];
		end
	end

	// ****************************************
	// Event status and interrupt
	// ****************************************
	logic [NUM_EVT-1:0] evt_set;
	logic bad_edge;

	always_comb begin
		bad_edge = 1'b0;
		for (int p = 0; p < NUM_PINS; p++) begin
			if (dat_i[EDGE_SEL_LSB + 2 * p +: 2] == EDGE_PROHIBITED) begin
				bad_edge = 1'b1;
			end
		end
		evt_set = '0;
		evt_set[EVT_NMI_TAKEN] = nmi_ack;
		evt_set[EVT_MASKABLE_TAKEN] = mask_ack;
		evt_set[EVT_BAD_EDGE] = wr_byte && hits(adr_i, OFF_EDGE_SEL) && bad_edge;
	end

	// Read clears, but an event on the same edge survives
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_status <= '0;
		end else if (rd_strobe && hits(adr_i, OFF_EVT_STATUS)) begin
			evt_status <= evt_set;
		end else begin
			evt_status <= evt_status | evt_set;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_mask <= '0;
		end else if (wr_byte && hits(adr_i, OFF_EVT_MASK)) begin
			evt_mask <= dat_i[NUM_EVT-1:0];
		end
	end

	assign irq_o = |(evt_status & evt_mask);

	// ****************************************
	// Bus answer
	// ****************************************
	logic [31:0] rd_data;

	always_comb begin
		rd_data = '0;
		if (hits(adr_i, OFF_REQ_LOW)) begin
			rd_data[LOW_FLAGS-1:0] = req_flags[LOW_FLAGS-1:0];
		end else if (hits(adr_i, OFF_REQ_HIGH)) begin
			rd_data[HIGH_FLAGS-1:0] = req_flags[NUM_SRC-1:LOW_FLAGS];
		end else if (hits(adr_i, OFF_MASK_LOW)) begin
			rd_data[7:0] = {MASK_RESET[7:LOW_FLAGS], mask_flags[LOW_FLAGS-1:0]};
		end else if (hits(adr_i, OFF_MASK_HIGH)) begin
			rd_data[7:0] = {MASK_RESET[7:HIGH_FLAGS], mask_flags[NUM_SRC-1:LOW_FLAGS]};
		end else if (hits(adr_i, OFF_EDGE_SEL)) begin
			rd_data[7:0] = edge_sel;
		end else if (hits(adr_i, OFF_PSW)) begin
			rd_data[7:0] = processor_status_word;
		end else if (hits(adr_i, OFF_WDT_MODE)) begin
			rd_data[0] = wdt_nmi_mode;
		end else if (hits(adr_i, OFF_EVT_STATUS)) begin
			rd_data[NUM_EVT-1:0] = evt_status;
		end else if (hits(adr_i, OFF_EVT_MASK)) begin
			rd_data[NUM_EVT-1:0] = evt_mask;
		end
	end

	// Unmapped addresses still answer, with zero data, so the bus never hangs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= access;
			if (rd_strobe) begin
				dat_o <= rd_data;
			end
		end
	end

endmodule

// ==== vic_props.sv ====
`timescale 1ns/1ns
// ********************************
// Offer and bus checks
// ********************************
module vic_props (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic ack_o,
	// Processor side
	input wire logic irq_ack_i,
	input wire logic irq_req_o,
	input wire logic irq_nmi_o,
	input wire logic [15:0] irq_vector_o,
	input wire logic standby_release_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic hold_ok;
	// Only an acknowledge or a software write may withdraw an offer
	assign hold_ok = !irq_ack_i && !(cyc_i && stb_i && we_i);
	reset_quiet_a: assert property (disable iff (1'b0)
		rst_i |=> !irq_req_o && !ack_o && !standby_release_o) else $error("outputs not quiet");
	nmi_offer_a: assert property (irq_nmi_o |-> irq_req_o) else $error("nmi not offered");
	nmi_vector_a: assert property (
		irq_nmi_o |-> irq_vector_o == 16'h0004) else $error("nmi vector wrong");
	standby_on_a: assert property (irq_req_o |-> standby_release_o) else $error("no standby");
	vector_legal_a: assert property (irq_req_o |-> irq_vector_o inside {16'h0004, 16'h0006,
		16'h0008, 16'h000a, 16'h000c, 16'h000e, 16'h0014, 16'h0016}) else $error("bad vector");
	ack_drop_a: assert property (irq_req_o && !irq_nmi_o && irq_ack_i
		|=> !irq_req_o || irq_nmi_o) else $error("offer stays after ack");
	pending_hold_a: assert property (irq_req_o && hold_ok |=> irq_req_o)
		else $error("offer lost");
	nmi_hold_a: assert property (irq_nmi_o && hold_ok |=> irq_nmi_o)
		else $error("nmi lost");
	bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	ack_pulse_a: assert property ($rose(ack_o) |=> $fell(ack_o)) else $error("ack too long");
	cover property (irq_nmi_o && irq_ack_i);
	cover property (irq_req_o && !irq_nmi_o && irq_ack_i);
	cover property (standby_release_o && !irq_req_o);
endmodule

bind vectored_interrupt_controller vic_props chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o),
	.irq_nmi_o(irq_nmi_o), .irq_vector_o(irq_vector_o), .standby_release_o(standby_release_o));

// ==== cpu_model.sv ====
`timescale 1ns/1ns
module cpu_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Offer from the controller, and answer delay
	input wire logic irq_req_i,
	input wire logic [15:0] irq_vector_i,
	input wire logic [3:0] delay_i,
	// Acknowledge and record
	output logic irq_ack_o,
	output logic [15:0] last_vec_o,
	output int n_acks_o
);
	logic [3:0] wait_cnt;
	// ********************************
	// Acknowledge a standing offer
	// ********************************
	// Slow answers stretch the window in which priorities can change
	always_ff @(posedge clk_i) begin
		if (rst_i || !irq_req_i || irq_ack_o) begin
			irq_ack_o <= 1'b0;
			wait_cnt <= 4'h0;
		end else if (wait_cnt >= delay_i) begin
			irq_ack_o <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			n_acks_o <= 0;
			last_vec_o <= 16'h0;
		end else if (irq_ack_o && irq_req_i) begin
			n_acks_o <= n_acks_o + 1;
			last_vec_o <= irq_vector_i;
		end
	end
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench;
	import vic_pkg::*;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_ack_i, irq_req_o, irq_nmi_o;
	logic standby_release_o, irq_o;
	logic [5:0] adr_i, src;
	logic [3:0] sel_i, cpu_delay;
	logic [31:0] dat_i, dat_o, q;
	logic [15:0] irq_vector_o, last_vec;
	logic [2:0] pins;
	logic [7:0] m, f, e;
	logic [15:0] vt [8] = '{16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c, 16'h000e,
		16'h0014, 16'h0016};
	int n_errors, checks_done, n_acks, n0, cycles, k;
	integer seed;

	vectored_interrupt_controller uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .watchdog_irq_i(src[0]), .async_rx_done_irq_i(src[1]),
		.three_wire_done_irq_i(src[2]), .async_tx_done_irq_i(src[3]),
		.byte_timer_match_irq_i(src[4]), .word_timer_match_irq_i(src[5]),
		.pin_irq_zero_i(pins[0]), .pin_irq_one_i(pins[1]), .pin_irq_two_i(pins[2]),
		.irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o), .irq_nmi_o(irq_nmi_o),
		.irq_vector_o(irq_vector_o), .standby_release_o(standby_release_o), .irq_o(irq_o));
	cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .irq_req_i(irq_req_o),
		.irq_vector_i(irq_vector_o), .delay_i(cpu_delay), .irq_ack_o(irq_ack_i),
		.last_vec_o(last_vec), .n_acks_o(n_acks));

	// ********************************
	// Helpers
	// ********************************
	function automatic int first(input logic [7:0] v);
		for (int i = 0; i < 8; i++) if (v[i]) return i;
		return 8;
	endfunction
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			$display("unexpected %s expected %h seen %h", nm, x, g);
			n_errors++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] x, input string nm);
		wb(1'b0, a, 8'h0);
		chk(nm, x, q);
	endtask
	task automatic take(input logic [15:0] x);
		n0 = n_acks;
		while (n_acks == n0) @(posedge clk_i);
		chk("vector", {16'h0, x}, {16'h0, last_vec});
	endtask
	task automatic pulse(input logic [5:0] s);
		@(posedge clk_i);
		src <= s;
		@(posedge clk_i);
		src <= 6'h0;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// Hang guard, far above the thousand or so cycles the run needs at most
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			final_report;
		end
	end

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		seed = 32'h03b8fa6c;
		{rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, src, pins, cpu_delay} = '0;
		rst_i = 1'b1;
		sel_i = 4'hf;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(OFF_REQ_LOW, 32'h0, "flags low");
		rd(OFF_MASK_LOW, 32'hff, "mask low");
		rd(OFF_MASK_HIGH, 32'hff, "mask high");
		rd(OFF_EDGE_SEL, 32'h0, "edge select");
		rd(OFF_PSW, 32'h02, "status word");
		rd(6'h24, 32'h0, "unmapped");
		for (int r = 0; r < 8; r++) begin
			m = (r == 0) ? 8'h00 : (r == 1) ? 8'hff : 8'($random(seed));
			k = (r < 2) ? 31 : $random(seed);
			cpu_delay <= 4'($random(seed));
			f = {k[4], k[3], k[2], k[1], 3'h0, k[0]};
			e = f & ~m;
			wb(1'b1, OFF_MASK_LOW, {2'h3, m[5:0]});
			wb(1'b1, OFF_MASK_HIGH, {6'h3f, m[7:6]});
			pulse({k[4], k[3], k[2], k[1] & k[5], k[1] & !k[5], k[0]});
			tick(1);
			chk("standby", {31'h0, |e}, {31'h0, standby_release_o});
			chk("offer", 32'h0, {31'h0, irq_req_o});
			rd(OFF_REQ_LOW, {26'h0, f[5:0]}, "flags low");
			rd(OFF_REQ_HIGH, {30'h0, f[7:6]}, "flags high");
			while (e != 8'h0) begin
				wb(1'b1, OFF_PSW, 8'h80);
				take(vt[first(e)]);
				e[first(e)] = 1'b0;
			end
			rd(OFF_REQ_LOW, {26'h0, f[5:0] & m[5:0]}, "pending");
			wb(1'b1, OFF_REQ_LOW, 8'h0);
			wb(1'b1, OFF_REQ_HIGH, 8'h0);
		end
		// Edge codes and the event line
		wb(1'b1, OFF_EVT_MASK, 8'h04);
		tick(1);
		chk("event line", 32'h0, {31'h0, irq_o});
		rd(OFF_EVT_STATUS, 32'h2, "event status");
		wb(1'b1, OFF_MASK_LOW, 8'hff);
		wb(1'b1, OFF_EDGE_SEL, 8'hb4);
		tick(1);
		chk("event line", 32'h1, {31'h0, irq_o});
		rd(OFF_EVT_STATUS, 32'h4, "event status");
		tick(1);
		chk("event line", 32'h0, {31'h0, irq_o});
		pins <= 3'h7;
		tick(10);
		rd(OFF_REQ_LOW, 32'h06, "rise edges");
		wb(1'b1, OFF_REQ_LOW, 8'h0);
		pins <= 3'h0;
		tick(10);
		rd(OFF_REQ_LOW, 32'h04, "fall edges");
		wb(1'b1, OFF_REQ_LOW, 8'h0);
		wb(1'b1, OFF_EDGE_SEL, 8'h00);
		pins <= 3'h7;
		tick(10);
		rd(OFF_REQ_LOW, 32'h0, "rise ignored");
		pins <= 3'h0;
		tick(10);
		rd(OFF_REQ_LOW, 32'h0e, "falling");
		for (k = 1; k < 4; k++) begin
			wb(1'b1, OFF_MASK_LOW, ~(8'h1 << k));
			wb(1'b1, OFF_PSW, 8'h80);
			take(vt[k]);
		end
		// Watchdog as the non-maskable source
		cpu_delay <= 4'h3;
		wb(1'b1, OFF_WDT_MODE, 8'h1);
		wb(1'b1, OFF_MASK_HIGH, 8'hfe);
		wb(1'b1, OFF_PSW, 8'h80);
		pulse(6'h11);
		tick(1);
		chk("nmi", 32'h1, {31'h0, irq_nmi_o});
		take(16'h0004);
		tick(1);
		chk("offer", 32'h0, {31'h0, irq_req_o});
		wb(1'b1, OFF_PSW, 8'h80);
		take(16'h0014);
		pulse(6'h01);
		tick(1);
		chk("nmi", 32'h1, {31'h0, irq_nmi_o});
		take(16'h0004);
		rd(OFF_EVT_STATUS, 32'h3, "event status");
		wb(1'b1, OFF_WDT_MODE, 8'h0);
		// Byte lane off, then a reset in mid-run
		sel_i <= 4'he;
		wb(1'b1, OFF_PSW, 8'h80);
		sel_i <= 4'hf;
		rd(OFF_PSW, 32'h0, "status word");
		wb(1'b1, OFF_REQ_HIGH, 8'h3);
		rd(OFF_REQ_HIGH, 32'h3, "flags set");
		rst_i <= 1'b1;
		tick(2);
		rst_i <= 1'b0;
		rd(OFF_REQ_HIGH, 32'h0, "flags high");
		rd(OFF_MASK_HIGH, 32'hff, "mask high");
		rd(OFF_PSW, 32'h02, "status word");
		chk("standby", 32'h0, {31'h0, standby_release_o});
		final_report;
	end
endmodule
